// ===== inc/spp_pkg.sv
// spp_pkg: shared constants and carriers for the sector and password protection block.
// assumes a host-side command decoder that presents one decoded protection command at a time.
package spp_pkg;

	localparam int SPR_W = 16;
	localparam int SPR_PWD_BIT = 2;
	localparam int SPR_SECT_BIT = 1;
	localparam logic [SPR_W-1:0] SPR_RESET = 16'hFFFF;
	localparam logic [SPR_W-1:0] SPR_OTP_MASK = 16'h0006;

	localparam int FRZ_W = 8;
	localparam int FRZ_BIT = 0;
	localparam logic FRZ_OPEN = 1'b1;
	localparam logic FRZ_SHUT = 1'b0;

	localparam int PWD_W = 64;
	localparam logic [PWD_W-1:0] PWD_INIT = 64'hFFFF_FFFF_FFFF_FFFF;

	localparam logic NVL_UNLOCKED = 1'b1;
	localparam logic NVL_LOCKED = 1'b0;
	localparam logic VL_UNLOCKED = 1'b0;
	localparam logic VL_LOCKED = 1'b1;

	localparam int SECTORS = 1024;
	localparam int SUBS = 16;
	localparam int SECT_W = 16;
	localparam int SUB_W = 4;

	typedef enum logic [3:0] {
		SPP_CMD_RD_SPR,
		SPP_CMD_WR_SPR,
		SPP_CMD_RD_FRZ,
		SPP_CMD_WR_FRZ,
		SPP_CMD_UNLOCK,
		SPP_CMD_WR_PWD,
		SPP_CMD_RD_PWD,
		SPP_CMD_WR_NVL,
		SPP_CMD_ERASE_NVL,
		SPP_CMD_RD_NVL,
		SPP_CMD_WR_VL,
		SPP_CMD_RD_VL,
		SPP_CMD_CHECK
	} spp_cmd_t;

	typedef struct packed {
		spp_cmd_t cmd;
		logic [SECT_W-1:0] sector;
		logic [SUB_W-1:0] sub;
		logic [PWD_W-1:0] data;
	} spp_req_t;

	typedef struct packed {
		logic valid;
		logic rejected;
		logic [PWD_W-1:0] data;
	} spp_rsp_t;

endpackage

// ===== hw/spp_lock_mem.sv
// spp_lock_mem: small bit-array memory with registered read and a whole-array clear.
// assumes one write and one read per cycle; clear takes priority over the write.
`timescale 1ns/1ps
module spp_lock_mem #(
	parameter int W = 1,
	parameter int DEPTH = 16,
	parameter logic [W-1:0] CLR_VAL = '0
) (
	input wire logic clk,
	input wire logic clr,
	input wire logic we,
	input wire logic [$clog2(DEPTH)-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem_ff [DEPTH];
	logic [W-1:0] rdata_ff;

	assign rdata = rdata_ff;

	// flop array rather than a macro: the lock-bit erase clears every entry in one cycle
	always_ff @(posedge clk)
	begin
		if (clr)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem_ff[i] <= CLR_VAL;
			rdata_ff <= CLR_VAL;
		end
		else
		begin
			if (we)
				mem_ff[waddr] <= wdata;
			rdata_ff <= mem_ff[raddr];
		end
	end
endmodule

// ===== hw/spp_protect.sv
// spp_protect: sector and password protection state of a serial flash, driven by decoded commands.
// assumes the command decoder waits for req_ready, and that factory_init is pulsed once
// to put the nonvolatile state into its as-delivered form; reset touches volatile state only.
//
// Notes on behaviour
// - 16-bit protection mode register; only bits 2 and 1 do anything.
// - one volatile freeze bit guards all nonvolatile lock bits.
// - one nonvolatile lock bit per sector, kept over reset until erased to 1.
// - one volatile lock bit per sector, cleared by every reset.
// - first and last sectors lock volatile per 4KB subsector; nonvolatile per sector.
// - bit 2 defaults 1; once 0, password is permanent, unreadable, unchangeable.
// - bit 1 defaults 1; programming it to 0 keeps bit 2 at 1 forever.
// - bits 2 and 1 are one-time programmable; both at 0 is refused.
// - host sets password first; once protected, password writes are rejected.
// - with password protection, freeze returns to 1 only with correct password.
// - freeze 1 allows lock-bit program and erase; freeze 0 rejects them.
// - freeze read returns freeze in bit 0, bits 7:1 zero.
// - with password protection, reset leaves freeze at 0.
// - correct password unlock sets freeze to 1.
// - freeze write sets freeze to 0, protecting nonvolatile lock bits.
// - as delivered every sector is unlocked in both lock sets.
// - nonvolatile lock 0 means locked; write clears, erase sets all to 1.
// - volatile lock 1 means locked; 0 unlocked, the reset state.
`timescale 1ns/1ps
module spp_protect #(
	parameter int SECTORS = spp_pkg::SECTORS,
	parameter int SUBS = spp_pkg::SUBS
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic factory_init,
	input wire logic req_valid,
	input wire spp_pkg::spp_req_t req,
	output logic req_ready,
	output spp_pkg::spp_rsp_t rsp,
	output logic freeze_open,
	output logic pwd_mode_on
);
	localparam int NAW = $clog2(SECTORS);
	localparam int VDEPTH = SECTORS + 2 * SUBS;
	localparam int VAW = $clog2(VDEPTH);

	logic ready_ff;
	logic stg_ff;
	spp_pkg::spp_req_t req_ff;
	spp_pkg::spp_rsp_t rsp_ff;
	logic frz_ff;
	logic [spp_pkg::SPR_W-1:0] spr_ff;
	logic [spp_pkg::PWD_W-1:0] pwd_ff;
	logic pwd_on_ff;

	logic take;
	logic nv_rd;
	logic v_rd;
	logic [NAW-1:0] nv_raddr;
	logic [NAW-1:0] nv_waddr;
	logic [VAW-1:0] v_raddr;
	logic [VAW-1:0] v_waddr;

	function automatic logic [VAW-1:0] vidx(input logic [spp_pkg::SECT_W-1:0] s,
		input logic [spp_pkg::SUB_W-1:0] b);
		logic [VAW-1:0] r;
		r = VAW'(s);
		if (s == '0)
			r = VAW'(SECTORS) + VAW'(b);
		else if (s == spp_pkg::SECT_W'(SECTORS - 1))
			r = VAW'(SECTORS + SUBS) + VAW'(b);
		return r;
	endfunction

	assign take = req_valid & ready_ff;
	assign nv_raddr = req.sector[NAW-1:0];
	assign nv_waddr = req_ff.sector[NAW-1:0];
	assign v_raddr = vidx(req.sector, req.sub);
	assign v_waddr = vidx(req_ff.sector, req_ff.sub);

	assign req_ready = ready_ff;
	assign rsp = rsp_ff;
	assign freeze_open = frz_ff;
	assign pwd_mode_on = pwd_on_ff;

	// decision for the command held in the stage
	logic pwd_on;
	logic [spp_pkg::SPR_W-1:0] spr_new;
	logic spr_bad;
	logic pwd_ok;
	logic d_rej;
	logic [spp_pkg::PWD_W-1:0] d_data;
	logic d_spr_we;
	logic d_pwd_we;
	logic d_frz_set;
	logic d_frz_clr;
	logic d_nv_we;
	logic d_nv_erase;
	logic d_v_we;

	assign pwd_on = ~spr_ff[spp_pkg::SPR_PWD_BIT];
	// programming only pulls the two live bits toward 0; reserved bits keep their 1s
	assign spr_new = spr_ff & (req_ff.data[spp_pkg::SPR_W-1:0] | ~spp_pkg::SPR_OTP_MASK);
	assign spr_bad = ~spr_new[spp_pkg::SPR_PWD_BIT] & ~spr_new[spp_pkg::SPR_SECT_BIT];
	assign pwd_ok = req_ff.data == pwd_ff;

	always_comb
	begin
		d_rej = 1'b0;
		d_data = '0;
		d_spr_we = 1'b0;
		d_pwd_we = 1'b0;
		d_frz_set = 1'b0;
		d_frz_clr = 1'b0;
		d_nv_we = 1'b0;
		d_nv_erase = 1'b0;
		d_v_we = 1'b0;
		case (req_ff.cmd)
			spp_pkg::SPP_CMD_RD_SPR:
				d_data = spp_pkg::PWD_W'(spr_ff);
			spp_pkg::SPP_CMD_WR_SPR:
			begin
				d_rej = spr_bad;
				d_spr_we = ~spr_bad;
			end
			spp_pkg::SPP_CMD_RD_FRZ:
				d_data = spp_pkg::PWD_W'({{(spp_pkg::FRZ_W-1){1'b0}}, frz_ff});
			spp_pkg::SPP_CMD_WR_FRZ:
				d_frz_clr = 1'b1;
			spp_pkg::SPP_CMD_UNLOCK:
			begin
				d_rej = pwd_on & ~pwd_ok;
				d_frz_set = ~d_rej;
			end
			spp_pkg::SPP_CMD_WR_PWD:
			begin
				d_rej = pwd_on;
				d_pwd_we = ~pwd_on;
			end
			spp_pkg::SPP_CMD_RD_PWD:
			begin
				d_rej = pwd_on;
				d_data = pwd_on ? '0 : pwd_ff;
			end
			spp_pkg::SPP_CMD_WR_NVL:
			begin
				d_rej = ~frz_ff;
				d_nv_we = frz_ff;
			end
			spp_pkg::SPP_CMD_ERASE_NVL:
			begin
				d_rej = ~frz_ff;
				d_nv_erase = frz_ff;
			end
			spp_pkg::SPP_CMD_RD_NVL:
				d_data = spp_pkg::PWD_W'(nv_rd);
			spp_pkg::SPP_CMD_WR_VL:
				d_v_we = 1'b1;
			spp_pkg::SPP_CMD_RD_VL:
				d_data = spp_pkg::PWD_W'(v_rd);
			spp_pkg::SPP_CMD_CHECK:
				// nonvolatile lock is per whole sector, volatile per subsector at the ends
				d_data = spp_pkg::PWD_W'((nv_rd == spp_pkg::NVL_LOCKED) |
					(v_rd == spp_pkg::VL_LOCKED));
			default:
				d_rej = 1'b1;
		endcase
	end

	logic nv_we;
	logic nv_clr;
	logic v_we;
	logic v_clr;

	assign nv_we = stg_ff & d_nv_we;
	assign nv_clr = factory_init | (stg_ff & d_nv_erase);
	assign v_we = stg_ff & d_v_we;
	assign v_clr = reset | factory_init;

	// write lock-bit command only ever locks; unlocking takes the erase
	spp_lock_mem #(
		.W(1),
		.DEPTH(SECTORS),
		.CLR_VAL(spp_pkg::NVL_UNLOCKED)
	) u_nv_locks (
		.clk(clk),
		.clr(nv_clr),
		.we(nv_we),
		.waddr(nv_waddr),
		.wdata(spp_pkg::NVL_LOCKED),
		.raddr(nv_raddr),
		.rdata(nv_rd)
	);

	spp_lock_mem #(
		.W(1),
		.DEPTH(VDEPTH),
		.CLR_VAL(spp_pkg::VL_UNLOCKED)
	) u_v_locks (
		.clk(clk),
		.clr(v_clr),
		.we(v_we),
		.waddr(v_waddr),
		.wdata(req_ff.data[0]),
		.raddr(v_raddr),
		.rdata(v_rd)
	);

	// command pipeline: take at one edge, answer at the next
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ready_ff <= 1'b1;
			stg_ff <= 1'b0;
			req_ff <= '0;
			rsp_ff <= '0;
		end
		else if (stg_ff)
		begin
			ready_ff <= 1'b1;
			stg_ff <= 1'b0;
			rsp_ff <= '{valid: 1'b1, rejected: d_rej, data: d_data};
		end
		else
		begin
			rsp_ff.valid <= 1'b0;
			if (take)
			begin
				ready_ff <= 1'b0;
				stg_ff <= 1'b1;
				req_ff <= req;
			end
		end
	end

	// freeze: the reset value follows the password mode bit, read straight from spr_ff
	// factory_init goes first: the mode bits return to delivered, so freeze must open
	always_ff @(posedge clk)
	begin
		if (factory_init)
			frz_ff <= spp_pkg::FRZ_OPEN;
		else if (reset)
			frz_ff <= spr_ff[spp_pkg::SPR_PWD_BIT];
		else if (stg_ff & d_frz_set)
			frz_ff <= spp_pkg::FRZ_OPEN;
		else if (stg_ff & d_frz_clr)
			frz_ff <= spp_pkg::FRZ_SHUT;
	end

	// nonvolatile register and password survive reset; only factory_init restores them
	always_ff @(posedge clk)
	begin
		if (factory_init)
		begin
			spr_ff <= spp_pkg::SPR_RESET;
			pwd_ff <= spp_pkg::PWD_INIT;
		end
		else
		begin
			if (stg_ff & d_spr_we)
				spr_ff <= spr_new;
			if (stg_ff & d_pwd_we)
				pwd_ff <= req_ff.data;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			pwd_on_ff <= 1'b0;
		else
			pwd_on_ff <= pwd_on;
	end

	AST_SPR_EXCL: assert property (@(posedge clk) disable iff (reset)
		!(spr_ff[spp_pkg::SPR_PWD_BIT] == 1'b0 && spr_ff[spp_pkg::SPR_SECT_BIT] == 1'b0))
		else $error("both mode bits programmed");

	AST_SPR_OTP: assert property (@(posedge clk) disable iff (reset)
		(!spr_ff[spp_pkg::SPR_PWD_BIT] && !factory_init) |=> !spr_ff[spp_pkg::SPR_PWD_BIT])
		else $error("password mode bit returned to 1");

	AST_SECT_HOLDS_PWD_OFF: assert property (@(posedge clk) disable iff (reset)
		(!spr_ff[spp_pkg::SPR_SECT_BIT] && !factory_init)
		|=> spr_ff[spp_pkg::SPR_PWD_BIT] && !spr_ff[spp_pkg::SPR_SECT_BIT])
		else $error("password mode enabled after sector bit programmed");

	AST_PWD_FIXED: assert property (@(posedge clk) disable iff (reset)
		(pwd_on && !factory_init) |=> $stable(pwd_ff))
		else $error("password changed under protection");

	AST_FRZ_AFTER_RESET: assert property (@(posedge clk) disable iff (reset)
		($past(reset) && pwd_on) |-> frz_ff == spp_pkg::FRZ_SHUT)
		else $error("freeze open after reset in password mode");

	AST_UNLOCK_OK: assert property (@(posedge clk) disable iff (reset)
		(stg_ff && req_ff.cmd == spp_pkg::SPP_CMD_UNLOCK && pwd_ok && !factory_init)
		|=> frz_ff == spp_pkg::FRZ_OPEN && rsp_ff.valid && !rsp_ff.rejected)
		else $error("correct password did not open freeze");

	AST_UNLOCK_BAD: assert property (@(posedge clk) disable iff (reset)
		(stg_ff && req_ff.cmd == spp_pkg::SPP_CMD_UNLOCK && pwd_on && !pwd_ok && !factory_init)
		|=> $stable(frz_ff) && rsp_ff.rejected)
		else $error("wrong password changed freeze");

	AST_FRZ_WRITE: assert property (@(posedge clk) disable iff (reset)
		(stg_ff && req_ff.cmd == spp_pkg::SPP_CMD_WR_FRZ && !factory_init)
		|=> frz_ff == spp_pkg::FRZ_SHUT)
		else $error("freeze write did not shut");

	AST_NVL_FROZEN: assert property (@(posedge clk) disable iff (reset)
		(stg_ff && !frz_ff && (req_ff.cmd == spp_pkg::SPP_CMD_WR_NVL ||
		req_ff.cmd == spp_pkg::SPP_CMD_ERASE_NVL))
		|-> !nv_we && !(nv_clr && !factory_init) ##1 rsp_ff.rejected)
		else $error("lock bit change while frozen");

	AST_FRZ_READ: assert property (@(posedge clk) disable iff (reset)
		(stg_ff && req_ff.cmd == spp_pkg::SPP_CMD_RD_FRZ)
		|=> rsp_ff.data == spp_pkg::PWD_W'($past(frz_ff)))
		else $error("freeze read value wrong");

	AST_RSP_TIMING: assert property (@(posedge clk) disable iff (reset)
		take |=> !req_ready ##1 rsp_ff.valid && req_ready)
		else $error("answer not two cycles after request");

	AST_REFUSED_STILL: assert property (@(posedge clk) disable iff (reset)
		(stg_ff && d_rej && !factory_init)
		|=> $stable(spr_ff) && $stable(pwd_ff) && $stable(frz_ff))
		else $error("refused command changed state");

	AST_NVL_ERASE: assert property (@(posedge clk) disable iff (reset)
		(stg_ff && req_ff.cmd == spp_pkg::SPP_CMD_ERASE_NVL && frz_ff)
		|=> nv_rd == spp_pkg::NVL_UNLOCKED)
		else $error("lock bit erase did not unlock");

	AST_VL_RESET: assert property (@(posedge clk)
		reset |=> v_rd == spp_pkg::VL_UNLOCKED)
		else $error("volatile lock kept over reset");

	AST_PWD_MODE_OUT: assert property (@(posedge clk) disable iff (reset)
		!$past(reset) |-> pwd_mode_on == $past(pwd_on))
		else $error("password mode output does not follow mode bit");
endmodule

// ===== tb/spp_host.sv
// spp_host: host controller model that issues one decoded protection command at a time.
// assumes the device takes a command on an edge with req_ready high and answers later.
`timescale 1ns/1ps
module spp_host (
	input wire logic clk,
	input wire logic req_ready,
	input wire spp_pkg::spp_rsp_t rsp,
	output spp_pkg::spp_req_t req,
	output logic req_valid
);
	initial
	begin
		req_valid = 1'b0;
		req = '0;
	end

	// called just after a rising edge; one command, one answer
	task automatic issue(input spp_pkg::spp_cmd_t c, input logic [15:0] s,
		input logic [3:0] u, input logic [63:0] d, output spp_pkg::spp_rsp_t r);
		int n;
		n = 0;
		req_valid <= 1'b1;
		req <= '{cmd: c, sector: s, sub: u, data: d};
		@(posedge clk);
		while (req_ready !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge clk);
		end
		req_valid <= 1'b0;
		// released fields flip so a late sample cannot match by luck
		req <= ~req;
		@(posedge clk);
		while (rsp.valid !== 1'b1 && n < 40)
		begin
			n++;
			@(posedge clk);
		end
		r = rsp;
	endtask
endmodule

// ===== tb/tb.sv
// tb: self-checking bench for spp_protect, commands issued through the host model.
// assumes small sector counts; reset and factory_init are driven here directly.
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic factory_init = 1'b1;
	logic req_valid;
	logic req_ready;
	logic freeze_open;
	logic pwd_mode_on;
	spp_pkg::spp_req_t req;
	spp_pkg::spp_rsp_t rsp;
	spp_pkg::spp_rsp_t last;
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;
	localparam logic [63:0] PW = 64'h0123_4567_89AB_CDEF;

	always #4 clk = ~clk;

	spp_protect #(.SECTORS(8), .SUBS(4)) dut_u (.clk(clk), .reset(reset),
		.factory_init(factory_init), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .rsp(rsp), .freeze_open(freeze_open),
		.pwd_mode_on(pwd_mode_on));
	spp_host host_u (.clk(clk), .req_ready(req_ready), .rsp(rsp), .req(req),
		.req_valid(req_valid));

	task automatic give_verdict();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_fail = n_fail + 1;
			give_verdict();
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input spp_pkg::spp_cmd_t c, input int s, input int u,
		input logic [63:0] d, input logic rej);
		host_u.issue(c, s[15:0], u[3:0], d, last);
		check({62'h0, last.valid, last.rejected}, {62'h0, 1'b1, rej});
	endtask

	task automatic rd(input spp_pkg::spp_cmd_t c, input int s, input int u,
		input logic [63:0] ed, input logic rej);
		wr(c, s, u, 64'h0, rej);
		check(last.data, ed);
	endtask

	// reset only; fi also reloads the as-delivered nonvolatile state
	task automatic hit_reset(input logic fi);
		reset <= 1'b1;
		factory_init <= fi;
		@(posedge clk);
		reset <= 1'b0;
		factory_init <= 1'b0;
		@(posedge clk);
	endtask

	task automatic t_defaults();
		rd(spp_pkg::SPP_CMD_RD_SPR, 0, 0, 64'hFFFF, 1'b0);
		rd(spp_pkg::SPP_CMD_RD_FRZ, 0, 0, 64'h1, 1'b0);
		rd(spp_pkg::SPP_CMD_CHECK, 7, 3, 64'h0, 1'b0);
		wr(spp_pkg::SPP_CMD_WR_SPR, 0, 0, 64'h0006, 1'b0);
		rd(spp_pkg::SPP_CMD_RD_SPR, 0, 0, 64'hFFFF, 1'b0);
	endtask

	task automatic t_locks();
		wr(spp_pkg::SPP_CMD_WR_NVL, 2, 0, 64'h0, 1'b0);
		rd(spp_pkg::SPP_CMD_RD_NVL, 2, 0, 64'h0, 1'b0);
		wr(spp_pkg::SPP_CMD_WR_VL, 5, 0, 64'h1, 1'b0);
		rd(spp_pkg::SPP_CMD_CHECK, 5, 3, 64'h1, 1'b0);
		rd(spp_pkg::SPP_CMD_RD_VL, 5, 0, 64'h1, 1'b0);
		wr(spp_pkg::SPP_CMD_WR_VL, 7, 1, 64'h1, 1'b0);
		rd(spp_pkg::SPP_CMD_CHECK, 7, 1, 64'h1, 1'b0);
		rd(spp_pkg::SPP_CMD_CHECK, 7, 2, 64'h0, 1'b0);
		wr(spp_pkg::SPP_CMD_WR_NVL, 0, 0, 64'h0, 1'b0);
		rd(spp_pkg::SPP_CMD_CHECK, 0, 2, 64'h1, 1'b0);
		wr(spp_pkg::SPP_CMD_ERASE_NVL, 0, 0, 64'h0, 1'b0);
		rd(spp_pkg::SPP_CMD_RD_NVL, 2, 0, 64'h1, 1'b0);
	endtask

	task automatic t_freeze();
		wr(spp_pkg::SPP_CMD_WR_NVL, 4, 0, 64'h0, 1'b0);
		wr(spp_pkg::SPP_CMD_WR_FRZ, 0, 0, 64'h0, 1'b0);
		check({63'h0, freeze_open}, 64'h0);
		rd(spp_pkg::SPP_CMD_RD_FRZ, 0, 0, 64'h0, 1'b0);
		wr(spp_pkg::SPP_CMD_WR_NVL, 1, 0, 64'h0, 1'b1);
		wr(spp_pkg::SPP_CMD_ERASE_NVL, 0, 0, 64'h0, 1'b1);
		rd(spp_pkg::SPP_CMD_RD_NVL, 4, 0, 64'h0, 1'b0);
		rd(spp_pkg::SPP_CMD_RD_NVL, 1, 0, 64'h1, 1'b0);
		wr(spp_pkg::SPP_CMD_UNLOCK, 0, 0, 64'h0, 1'b0);
		rd(spp_pkg::SPP_CMD_RD_FRZ, 0, 0, 64'h1, 1'b0);
		hit_reset(1'b0);
		rd(spp_pkg::SPP_CMD_CHECK, 5, 0, 64'h0, 1'b0);
		rd(spp_pkg::SPP_CMD_RD_NVL, 4, 0, 64'h0, 1'b0);
	endtask

	task automatic t_password();
		wr(spp_pkg::SPP_CMD_WR_PWD, 0, 0, PW, 1'b0);
		rd(spp_pkg::SPP_CMD_RD_PWD, 0, 0, PW, 1'b0);
		wr(spp_pkg::SPP_CMD_WR_SPR, 0, 0, 64'hFFFB, 1'b0);
		rd(spp_pkg::SPP_CMD_RD_SPR, 0, 0, 64'hFFFB, 1'b0);
		check({63'h0, pwd_mode_on}, 64'h1);
		wr(spp_pkg::SPP_CMD_WR_SPR, 0, 0, 64'hFFF9, 1'b1);
		rd(spp_pkg::SPP_CMD_RD_SPR, 0, 0, 64'hFFFB, 1'b0);
		wr(spp_pkg::SPP_CMD_WR_PWD, 0, 0, 64'h5, 1'b1);
		rd(spp_pkg::SPP_CMD_RD_PWD, 0, 0, 64'h0, 1'b1);
		hit_reset(1'b0);
		rd(spp_pkg::SPP_CMD_RD_FRZ, 0, 0, 64'h0, 1'b0);
		wr(spp_pkg::SPP_CMD_UNLOCK, 0, 0, ~PW, 1'b1);
		wr(spp_pkg::SPP_CMD_WR_NVL, 3, 0, 64'h0, 1'b1);
		wr(spp_pkg::SPP_CMD_UNLOCK, 0, 0, PW, 1'b0);
		wr(spp_pkg::SPP_CMD_WR_NVL, 3, 0, 64'h0, 1'b0);
		rd(spp_pkg::SPP_CMD_RD_NVL, 3, 0, 64'h0, 1'b0);
	endtask

	task automatic t_sect_mode();
		hit_reset(1'b1);
		rd(spp_pkg::SPP_CMD_RD_NVL, 3, 0, 64'h1, 1'b0);
		rd(spp_pkg::SPP_CMD_RD_FRZ, 0, 0, 64'h1, 1'b0);
		wr(spp_pkg::SPP_CMD_WR_SPR, 0, 0, 64'hFFFD, 1'b0);
		wr(spp_pkg::SPP_CMD_WR_SPR, 0, 0, 64'hFFFB, 1'b1);
		rd(spp_pkg::SPP_CMD_RD_SPR, 0, 0, 64'hFFFD, 1'b0);
		check({63'h0, pwd_mode_on}, 64'h0);
	endtask

	initial
	begin
		@(posedge clk);
		factory_init <= 1'b0;
		repeat (7) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_defaults();
		t_locks();
		t_freeze();
		t_password();
		t_sect_mode();
		give_verdict();
	end
endmodule
